/* File: rtl/pld_defines.svh */
// Offsets, fields, reset values and timing counts of the lock detect and calibration block
`ifndef PLD_DEFINES_SVH
`define PLD_DEFINES_SVH

`define PLD_ADDR_W          8
`define PLD_OFS_STAGE       8'h00
`define PLD_OFS_UPDATE      8'h04
`define PLD_OFS_ACTIVE      8'h08
`define PLD_OFS_STATUS      8'h0c
`define PLD_OFS_INT_STATUS  8'h10
`define PLD_OFS_INT_MASK    8'h14

`define PLD_BIT_CAL_START   0
`define PLD_BIT_DIV_LSB     1
`define PLD_BIT_DIV_MSB     2
`define PLD_BIT_LD_DISABLE  3
`define PLD_BIT_WIN_LOW     4
`define PLD_BIT_CNT_LSB     5
`define PLD_BIT_CNT_MSB     6
`define PLD_BIT_UPDATE      0
`define PLD_CTRL_RESET      7'h06

`define PLD_INT_LOCK_GAINED 0
`define PLD_INT_LOCK_LOST   1
`define PLD_INT_CAL_DONE    2

`define PLD_LOCK_CNT_0      8'h05
`define PLD_LOCK_CNT_1      8'h10
`define PLD_LOCK_CNT_2      8'h40
`define PLD_LOCK_CNT_3      8'hff

`define PLD_CLK_PERIOD_NS   25
`define PLD_WIN_HIGH_NS     200
`define PLD_WIN_LOW_NS      75
`define PLD_LOSS_HIGH_NS    400
`define PLD_LOSS_LOW_NS     150
`define PLD_WIN_HIGH_CYC    (`PLD_WIN_HIGH_NS / `PLD_CLK_PERIOD_NS)
`define PLD_WIN_LOW_CYC     (`PLD_WIN_LOW_NS / `PLD_CLK_PERIOD_NS)
`define PLD_LOSS_HIGH_CYC   (`PLD_LOSS_HIGH_NS / `PLD_CLK_PERIOD_NS)
`define PLD_LOSS_LOW_CYC    (`PLD_LOSS_LOW_NS / `PLD_CLK_PERIOD_NS)
`define PLD_CAL_PERIODS     8'h10

`endif

/* File: rtl/pld_pkg.sv */
// Types of the lock detect and calibration block
package pld_pkg;

  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } pld_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } pld_apb_rsp_type;

  typedef enum logic [1:0] {
    PAIR_IDLE,
    PAIR_WAIT_FB,
    PAIR_WAIT_REF
  } pld_pair_type;

  typedef struct packed {
    logic [2:0]   ref_sync;
    logic [2:0]   fb_sync;
    logic [6:0]   stage;
    logic [6:0]   active;
    logic [2:0]   int_status;
    logic [2:0]   int_mask;
    logic [31:0]  rdata;
    logic         slverr;
    pld_pair_type pair;
    logic [7:0]   gap_cnt;
    logic [7:0]   good_cnt;
    logic         locked;
    logic [2:0]   div_cnt;
    logic         cal_clk;
    logic         cal_busy;
    logic [7:0]   cal_cnt;
  } pld_state_type;

endpackage : pld_pkg

/* File: rtl/pld_lock_cal.sv */
// Digital lock detector and oscillator calibration control with APB registers
`timescale 1ns/10ps
`include "pld_defines.svh"

module pld_lock_cal (
  input  wire logic                     clk_sys_in,
  input  wire logic                     rst_n_in,
  input  wire pld_pkg::pld_apb_req_type apb_req_in,
  output pld_pkg::pld_apb_rsp_type      apb_rsp_out,
  input  wire logic                     phase_comparator_ref_in,
  input  wire logic                     phase_comparator_fb_in,
  output logic                          lock_detect_out,
  output logic                          cal_clk_out,
  output logic                          osc_calibration_start_out,
  output logic                          irq_out
);
  import pld_pkg::*;

  pld_state_type s_reg;
  pld_state_type s_next;

  logic        ref_rise;
  logic        fb_rise;
  logic        wr_acc;
  logic        rd_acc;
  logic        setup;
  logic        mapped;
  logic [7:0]  addr;
  logic [7:0]  win_cyc;
  logic [7:0]  loss_cyc;
  logic [7:0]  need_cnt;
  logic [2:0]  div_half;
  logic        eval;
  logic [7:0]  gap;
  logic [2:0]  events;
  logic        ld_disable;

  always_comb begin
    addr       = apb_req_in.paddr;
    setup      = apb_req_in.psel && !apb_req_in.penable;
    wr_acc     = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite;
    rd_acc     = apb_req_in.psel && apb_req_in.penable && !apb_req_in.pwrite;
    mapped     = (addr == `PLD_OFS_STAGE) || (addr == `PLD_OFS_UPDATE) ||
                 (addr == `PLD_OFS_ACTIVE) || (addr == `PLD_OFS_STATUS) ||
                 (addr == `PLD_OFS_INT_STATUS) || (addr == `PLD_OFS_INT_MASK);
    // Stage 1 feeds only stage 2; edges come from stages 2 and 3
    ref_rise   = s_reg.ref_sync[1] && !s_reg.ref_sync[2];
    fb_rise    = s_reg.fb_sync[1] && !s_reg.fb_sync[2];
    ld_disable = s_reg.active[`PLD_BIT_LD_DISABLE];
    if (s_reg.active[`PLD_BIT_WIN_LOW]) begin
      win_cyc  = 8'(`PLD_WIN_LOW_CYC);
      loss_cyc = 8'(`PLD_LOSS_LOW_CYC);
    end else begin
      win_cyc  = 8'(`PLD_WIN_HIGH_CYC);
      loss_cyc = 8'(`PLD_LOSS_HIGH_CYC);
    end
    case (s_reg.active[`PLD_BIT_CNT_MSB:`PLD_BIT_CNT_LSB])
      2'h0:    need_cnt = `PLD_LOCK_CNT_0;
      2'h1:    need_cnt = `PLD_LOCK_CNT_1;
      2'h2:    need_cnt = `PLD_LOCK_CNT_2;
      default: need_cnt = `PLD_LOCK_CNT_3;
    endcase
    case (s_reg.active[`PLD_BIT_DIV_MSB:`PLD_BIT_DIV_LSB])
      2'h0:    div_half = 3'h0;
      2'h1:    div_half = 3'h1;
      2'h2:    div_half = 3'h3;
      default: div_half = 3'h7;
    endcase
  end

  always_comb begin
    s_next          = s_reg;
    events          = 3'h0;
    eval            = 1'b0;
    gap             = 8'h00;
    s_next.ref_sync = {s_reg.ref_sync[1:0], phase_comparator_ref_in};
    s_next.fb_sync  = {s_reg.fb_sync[1:0], phase_comparator_fb_in};

    // Edge pairing: gap counted in system cycles from the first edge
    case (s_reg.pair)
      PAIR_IDLE: begin
        s_next.gap_cnt = 8'h01;
        if (ref_rise && fb_rise) begin
          eval = 1'b1;
        end else if (ref_rise) begin
          s_next.pair = PAIR_WAIT_FB;
        end else if (fb_rise) begin
          s_next.pair = PAIR_WAIT_REF;
        end
      end
      PAIR_WAIT_FB, PAIR_WAIT_REF: begin
        if ((s_reg.pair == PAIR_WAIT_FB) ? fb_rise : ref_rise) begin
          eval        = 1'b1;
          gap         = s_reg.gap_cnt;
          s_next.pair = PAIR_IDLE;
        end else if (s_reg.gap_cnt > loss_cyc) begin
          // Missing partner edge counts as a gap beyond the loss threshold
          eval        = 1'b1;
          gap         = s_reg.gap_cnt;
          s_next.pair = PAIR_IDLE;
        end else begin
          s_next.gap_cnt = s_reg.gap_cnt + 8'h01;
        end
      end
      default: s_next.pair = PAIR_IDLE;
    endcase

    if (ld_disable) begin
      s_next.pair     = PAIR_IDLE;
      s_next.good_cnt = 8'h00;
      s_next.locked   = 1'b0;
      if (s_reg.locked) begin
        events[`PLD_INT_LOCK_LOST] = 1'b1;
      end
    end else if (eval) begin
      if (gap < win_cyc) begin
        if (!s_reg.locked) begin
          if (s_reg.good_cnt + 8'h01 >= need_cnt) begin
            s_next.locked   = 1'b1;
            s_next.good_cnt = 8'h00;
            events[`PLD_INT_LOCK_GAINED] = 1'b1;
          end else begin
            s_next.good_cnt = s_reg.good_cnt + 8'h01;
          end
        end
      end else if (gap > loss_cyc) begin
        s_next.good_cnt = 8'h00;
        s_next.locked   = 1'b0;
        if (s_reg.locked) begin
          events[`PLD_INT_LOCK_LOST] = 1'b1;
        end
      end else if (!s_reg.locked) begin
        // Between window and threshold: an unlocked count restarts
        s_next.good_cnt = 8'h00;
      end
    end

    // Calibration clock: toggles every half ratio of reference edges
    if (ref_rise) begin
      if (s_reg.div_cnt >= div_half) begin
        s_next.div_cnt = 3'h0;
        s_next.cal_clk = !s_reg.cal_clk;
        if (s_reg.cal_busy && !s_reg.cal_clk) begin
          if (s_reg.cal_cnt + 8'h01 >= `PLD_CAL_PERIODS) begin
            s_next.cal_busy = 1'b0;
            events[`PLD_INT_CAL_DONE] = 1'b1;
          end else begin
            s_next.cal_cnt = s_reg.cal_cnt + 8'h01;
          end
        end
      end else begin
        s_next.div_cnt = s_reg.div_cnt + 3'h1;
      end
    end

    // APB: read data prepared in setup, presented in a zero-wait access
    if (setup) begin
      s_next.slverr = !mapped;
      case (addr)
        `PLD_OFS_STAGE:      s_next.rdata = {25'h0, s_reg.stage};
        `PLD_OFS_ACTIVE:     s_next.rdata = {25'h0, s_reg.active};
        `PLD_OFS_STATUS:     s_next.rdata = {30'h0, s_reg.cal_busy, s_reg.locked};
        `PLD_OFS_INT_STATUS: s_next.rdata = {29'h0, s_reg.int_status};
        `PLD_OFS_INT_MASK:   s_next.rdata = {29'h0, s_reg.int_mask};
        default:             s_next.rdata = 32'h0;
      endcase
    end

    if (wr_acc) begin
      case (addr)
        `PLD_OFS_STAGE:    s_next.stage    = apb_req_in.pwdata[6:0];
        `PLD_OFS_INT_MASK: s_next.int_mask = apb_req_in.pwdata[2:0];
        `PLD_OFS_UPDATE: begin
          // Update reads back zero: it acts once and is never stored
          if (apb_req_in.pwdata[`PLD_BIT_UPDATE]) begin
            s_next.active = s_reg.stage;
            // Only a 0-to-1 change of the active bit starts a run
            if (s_reg.stage[`PLD_BIT_CAL_START] &&
                !s_reg.active[`PLD_BIT_CAL_START]) begin
              s_next.cal_busy = 1'b1;
              s_next.cal_cnt  = 8'h00;
            end
          end
        end
        default: s_next.int_mask = s_reg.int_mask;
      endcase
    end

    // Read clears only the bits captured at setup; later events survive
    if (rd_acc && addr == `PLD_OFS_INT_STATUS) begin
      s_next.int_status = (s_reg.int_status & ~s_reg.rdata[2:0]) | events;
    end else begin
      s_next.int_status = s_reg.int_status | events;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_reg            <= '0;
      s_reg.pair       <= PAIR_IDLE;
      s_reg.stage      <= `PLD_CTRL_RESET;
      s_reg.active     <= `PLD_CTRL_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  always_comb begin
    apb_rsp_out.prdata        = s_reg.rdata;
    apb_rsp_out.pready        = 1'b1;
    apb_rsp_out.pslverr       = s_reg.slverr && apb_req_in.psel && apb_req_in.penable;
    lock_detect_out           = s_reg.locked;
    cal_clk_out               = s_reg.cal_clk;
    osc_calibration_start_out = s_reg.cal_busy;
    irq_out                   = |(s_reg.int_status & s_reg.int_mask);
  end

endmodule : pld_lock_cal

/* File: verif/pld_lock_cal_props.sv */
// Port checker for the lock detect and calibration block
`timescale 1ns/10ps
module pld_lock_cal_props (
  input wire logic                     clk_sys_in,
  input wire logic                     rst_n_in,
  input wire pld_pkg::pld_apb_req_type apb_req_in,
  input wire pld_pkg::pld_apb_rsp_type apb_rsp_out,
  input wire logic                     phase_comparator_ref_in,
  input wire logic                     phase_comparator_fb_in,
  input wire logic                     lock_detect_out,
  input wire logic                     cal_clk_out,
  input wire logic                     osc_calibration_start_out,
  input wire logic                     irq_out
);
  import pld_pkg::*;
  logic       acc, bad, upd_wr, mask0_wr, ref_q, fb_q;
  logic [7:0] ref_age, fb_cnt;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  assign acc = apb_req_in.psel & apb_req_in.penable;
  assign bad = apb_req_in.paddr > 8'h14 || apb_req_in.paddr[1:0] != 2'h0;
  assign upd_wr = acc & apb_req_in.pwrite & apb_req_in.paddr == 8'h04 & apb_req_in.pwdata[0];
  assign mask0_wr = acc & apb_req_in.pwrite & apb_req_in.paddr == 8'h14
                    & apb_req_in.pwdata[2:0] == 3'h0;
  // Lock must be earned by feedback edges seen while unlocked
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ref_q   <= 1'b0;
      fb_q    <= 1'b0;
      ref_age <= 8'hff;
      fb_cnt  <= 8'h00;
    end else begin
      ref_q <= phase_comparator_ref_in;
      fb_q  <= phase_comparator_fb_in;
      if (phase_comparator_ref_in && !ref_q) ref_age <= 8'h00;
      else if (ref_age != 8'hff) ref_age <= ref_age + 8'h01;
      if (lock_detect_out) fb_cnt <= 8'h00;
      else if (phase_comparator_fb_in && !fb_q && fb_cnt != 8'hff) fb_cnt <= fb_cnt + 8'h01;
    end
  end
  AST_READY: assert property (apb_req_in.psel |-> apb_rsp_out.pready)
    else $error("pready low during transfer");
  AST_SLVERR: assert property (acc |-> apb_rsp_out.pslverr == bad)
    else $error("pslverr does not match address");
  AST_UPD_READ: assert property (acc && !apb_req_in.pwrite && apb_req_in.paddr == 8'h04 |->
    apb_rsp_out.prdata == 32'h0) else $error("update register reads nonzero");
  AST_CAL_RISE: assert property ($rose(osc_calibration_start_out) |->
    $past(upd_wr) || $past(upd_wr, 2)) else $error("calibration began without update");
  AST_CAL_HOLD: assert property ($rose(osc_calibration_start_out) |->
    osc_calibration_start_out[*8]) else $error("calibration ended too soon");
  AST_CAL_CLK: assert property ($changed(cal_clk_out) |-> ref_age <= 8'h06)
    else $error("calibration clock moved without reference edge");
  AST_LOCK_CNT: assert property ($rose(lock_detect_out) |-> fb_cnt >= 8'h05)
    else $error("lock declared after too few cycles");
  AST_LOCK_EDGE: assert property ($rose(lock_detect_out) |-> ref_age < 8'h14)
    else $error("lock declared without recent edges");
  AST_IRQ_MASK: assert property (mask0_wr |-> ##2 !irq_out)
    else $error("interrupt high with all sources masked");
  cover property ($rose(lock_detect_out));
  cover property ($fell(lock_detect_out));
  cover property ($fell(osc_calibration_start_out));
endmodule : pld_lock_cal_props

/* File: verif/pld_lock_cal_tb_top.sv */
// Testbench for the lock detect and calibration block
`timescale 1ns/10ps
module pld_lock_cal_tb_top;
  import pld_pkg::*;
  logic            clk_sys_in, rst_n_in, ref_in, fb_in, lock, cal_clk, cal_go, irq, err;
  pld_apb_req_type req;
  pld_apb_rsp_type rsp;
  logic [31:0]     rd;
  int              num_errors, n_compared, rises;
  // Row: write, address, write data, expected read, expected error
  logic [73:0]     rows [12] = '{
    {1'b0, 8'h00, 32'h0, 32'h06, 1'b0}, {1'b0, 8'h08, 32'h0, 32'h06, 1'b0},
    {1'b0, 8'h14, 32'h0, 32'h00, 1'b0}, {1'b0, 8'h04, 32'h0, 32'h00, 1'b0},
    {1'b1, 8'h00, 32'h10, 32'h0, 1'b0}, {1'b0, 8'h08, 32'h0, 32'h06, 1'b0},
    {1'b1, 8'h04, 32'h1, 32'h00, 1'b0}, {1'b0, 8'h08, 32'h0, 32'h10, 1'b0},
    {1'b0, 8'h04, 32'h0, 32'h00, 1'b0}, {1'b1, 8'h08, 32'h7f, 32'h0, 1'b0},
    {1'b0, 8'h08, 32'h0, 32'h10, 1'b0}, {1'b0, 8'h18, 32'h0, 32'h00, 1'b1}};

  pld_lock_cal pld_lock_cal_inst (
    .clk_sys_in                (clk_sys_in),
    .rst_n_in                  (rst_n_in),
    .apb_req_in                (req),
    .apb_rsp_out               (rsp),
    .phase_comparator_ref_in   (ref_in),
    .phase_comparator_fb_in    (fb_in),
    .lock_detect_out           (lock),
    .cal_clk_out               (cal_clk),
    .osc_calibration_start_out (cal_go),
    .irq_out                   (irq)
  );

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge clk_sys_in);
    req.penable <= 1'b1;
    do @(posedge clk_sys_in); while (rsp.pready !== 1'b1);
    rd  = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : apb

  // Gap g in system cycles from reference edge to feedback edge
  task automatic pairs(input int n, input int g);
    repeat (n) begin
      ref_in <= 1'b1;
      repeat (g) @(posedge clk_sys_in);
      fb_in <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      ref_in <= 1'b0;
      fb_in  <= 1'b0;
      repeat (12) @(posedge clk_sys_in);
    end
  endtask : pairs

  task automatic close_out;
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  always @(posedge cal_clk) rises++;

  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    repeat (10000) @(posedge clk_sys_in);
    num_errors++;
    close_out();
  end

  initial begin
    {rst_n_in, ref_in, fb_in, req} = '0;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i][73], rows[i][72:65], rows[i][64:33]);
      if (!rows[i][73]) chk("prdata", rows[i][32:1], rd);
      chk("pslverr", 32'(rows[i][0]), 32'(err));
    end
    apb(1'b1, 8'h14, 32'h1);
    pairs(6, 4);
    chk("lock low window", 32'h0, 32'(lock));
    apb(1'b1, 8'h00, 32'h06);
    apb(1'b1, 8'h04, 32'h1);
    pairs(4, 4);
    chk("lock after 4", 32'h0, 32'(lock));
    pairs(1, 4);
    chk("lock after 5", 32'h1, 32'(lock));
    chk("irq", 32'h1, 32'(irq));
    apb(1'b1, 8'h14, 32'h0);
    @(posedge clk_sys_in);
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'b0, 8'h10, 32'h0);
    chk("int status", 32'h1, rd);
    pairs(3, 10);
    chk("lock hysteresis", 32'h1, 32'(lock));
    pairs(1, 20);
    chk("lock lost", 32'h0, 32'(lock));
    apb(1'b0, 8'h10, 32'h0);
    chk("int status lost", 32'h2, rd);
    apb(1'b1, 8'h00, 32'h0e);
    apb(1'b1, 8'h04, 32'h1);
    pairs(6, 2);
    chk("lock disabled", 32'h0, 32'(lock));
    apb(1'b1, 8'h00, 32'h26);
    apb(1'b1, 8'h04, 32'h1);
    pairs(1, 20);
    // Let the orphan feedback edge time out before new pairs
    repeat (20) @(posedge clk_sys_in);
    pairs(15, 2);
    chk("lock after 15", 32'h0, 32'(lock));
    pairs(1, 2);
    chk("lock after 16", 32'h1, 32'(lock));
    // Start bit cleared then set, each committed by update
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h04, 32'h1);
    repeat (3) @(posedge clk_sys_in);
    chk("cal start", 32'h1, 32'(cal_go));
    rises = 0;
    pairs(10, 2);
    chk("cal clk div 2", 32'h1, 32'(rises >= 4 && rises <= 6));
    pairs(30, 2);
    chk("cal done", 32'h0, 32'(cal_go));
    apb(1'b0, 8'h10, 32'h0);
    chk("cal done int", 32'h1, 32'(rd[2]));
    apb(1'b1, 8'h04, 32'h1);
    repeat (3) @(posedge clk_sys_in);
    chk("cal static high", 32'h0, 32'(cal_go));
    rst_n_in <= 1'b0;
    @(posedge clk_sys_in);
    chk("lock in reset", 32'h0, 32'(lock));
    chk("irq in reset", 32'h0, 32'(irq));
    rst_n_in <= 1'b1;
    apb(1'b0, 8'h08, 32'h0);
    chk("active after reset", 32'h06, rd);
    close_out();
  end
endmodule : pld_lock_cal_tb_top

bind pld_lock_cal pld_lock_cal_props pld_lock_cal_props_inst (
  .clk_sys_in, .rst_n_in, .apb_req_in, .apb_rsp_out, .phase_comparator_ref_in,
  .phase_comparator_fb_in, .lock_detect_out, .cal_clk_out, .osc_calibration_start_out, .irq_out);
